// >>> sarcc_afe_model.sv
// Sample-hold and comparator front end model facing the converter
`timescale 1ns/1ps
`default_nettype none
module sarcc_afe_model
(
	input  wire logic       clk,
	input  wire logic       comp_enable,
	input  wire logic       sample,
	input  wire logic [9:0] tap,
	input  wire logic [9:0] level,
	output logic            comp_out
);
	logic [9:0] held_q;
	logic       junk_q;

	// Track the input while sampling, hold afterwards without droop for any sampling time
	always @(posedge clk)
	begin
		if (sample)
			held_q <= level;
		junk_q <= ~junk_q;
	end

	// Decision against the tap; a stopped comparator gives no usable answer
	assign comp_out = comp_enable ? (held_q >= tap) : junk_q;
	initial junk_q = 1'b0;
endmodule // sarcc_afe_model
`default_nettype wire

// >>> sarcc_fad_div.sv
// Conversion clock tick generator from the peripheral clock
`timescale 1ns/1ps
`default_nettype none
module sarcc_fad_div
	import sarcc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [2:0] divider_sel,
	output logic            tick
);
	logic [3:0] cnt_q;
	logic [3:0] len;

	assign len  = sarcc_div_len(divider_sel);
	assign tick = run && (cnt_q == (len - 4'h1));

	// Free count while running, restart when stopped
	always_ff @(posedge clk)
	begin
		if (rst || !run)
			cnt_q <= 4'h0;
		else if (cnt_q >= (len - 4'h1))
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_q + 4'h1;
	end

	chk_tick_spacing: assert property (@(posedge clk) disable iff (rst) tick |=> !tick)
		else $error("conversion tick repeated on consecutive clocks");
endmodule // sarcc_fad_div
`default_nettype wire

// >>> sarcc_pkg.sv
// Package: register map, field layout and sequence counts of the SAR converter control
`default_nettype none
package sarcc_pkg;
	// Register addresses on the CPU memory bus
	localparam logic [15:0] ADDR_RESULT_WIDE  = 16'hFF08;
	localparam logic [15:0] ADDR_RESULT_UPPER = 16'hFF09;
	localparam logic [15:0] ADDR_MODE         = 16'hFF28;
	localparam logic [15:0] ADDR_CHANNEL      = 16'hFF29;
	localparam logic [15:0] ADDR_PIN_CFG      = 16'hFF2F;

	// Reset values
	localparam logic [7:0]  MODE_RESET         = 8'h00;
	localparam logic [2:0]  CHANNEL_RESET      = 3'h0;
	localparam logic [3:0]  PIN_CFG_RESET      = 4'h0;
	localparam logic [15:0] RESULT_WIDE_RESET  = 16'h0000;
	localparam logic [7:0]  RESULT_UPPER_RESET = 8'h00;
	localparam logic [9:0]  SAR_RESET          = 10'h000;

	// Field layout
	localparam logic [9:0]  SAR_FIRST_TRIAL = 10'h200;
	localparam logic [5:0]  RESULT_PAD      = 6'h00;
	localparam logic [3:0]  SAR_TOP_BIT     = 4'h9;
	localparam logic [7:0]  MODE_WR_MASK    = 8'hBF;

	// Sequence lengths in conversion-clock ticks
	localparam logic [4:0]  TICKS_CLEAR      = 5'h02;
	localparam logic [4:0]  TICKS_SAMPLE_LOW = 5'h18;
	localparam logic [4:0]  TICKS_SAMPLE_STD = 5'h06;
	localparam logic [4:0]  TICKS_COMPARE    = 5'h0C;
	localparam logic [4:0]  TICKS_RESOLVE    = 5'h0A;
	localparam logic [4:0]  TICKS_TRANSFER   = 5'h02;
	localparam logic [1:0]  LEVEL_LOW_REF    = 2'h1;

	// Mode register fields, bit 7 down to bit 0
	typedef struct packed {
		logic       conv_enable;
		logic       zero_bit;
		logic [2:0] divider_sel;
		logic [1:0] level_sel;
		logic       comparator_enable;
	} sarcc_mode_t;

	typedef enum logic [2:0] {ST_IDLE, ST_CLEAR, ST_SAMPLE, ST_COMPARE, ST_TRANSFER} sarcc_state_t;

	// Peripheral clocks per conversion clock; prohibited codes fall back to the slowest
	function automatic logic [3:0] sarcc_div_len(input logic [2:0] sel);
		case (sel)
			3'h0:    sarcc_div_len = 4'hC;
			3'h1:    sarcc_div_len = 4'h8;
			3'h2:    sarcc_div_len = 4'h6;
			3'h3:    sarcc_div_len = 4'h4;
			3'h4:    sarcc_div_len = 4'h3;
			3'h5:    sarcc_div_len = 4'h2;
			default: sarcc_div_len = 4'hC;
		endcase
	endfunction

	// Sampling ticks for the selected reference level
	function automatic logic [4:0] sarcc_sample_len(input logic [1:0] lv);
		sarcc_sample_len = (lv == LEVEL_LOW_REF) ? TICKS_SAMPLE_LOW : TICKS_SAMPLE_STD;
	endfunction
endpackage
`default_nettype wire

// >>> sarcc_top.sv
// SAR converter sequencer, result registers and channel select behind the CPU bus
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Divider codes 0..5 give /12,/8,/6,/4,/3,/2 conversion clocks; others prohibited.
// - Low-reference conversion: 2 clear, 24 sample, 12 compare, 2 transfer ticks.
// - Wide result holds ten bits left-aligned; low six bits read zero.
// - Upper byte carries result bits 9..2; lower byte top holds bits 1..0.
// - Each conversion end loads the approximation register into result registers.
// - Wide result is readable only by a single 16-bit access.
// - Reset clears the wide result register to zero.
// - Mode, channel or pin writes may leave wide result undefined.
// - Reading the wide result inserts one bus wait cycle.
// - Byte result register presents upper eight bits of the result.
// - Byte result is read by 8-bit access and resets to zero.
// - Byte result may go undefined on those writes; reading it waits.
// - Three-bit channel field selects analog input 0..7; resets to zero.
// - Writing the channel select register inserts one bus wait cycle.
// - Conversions repeat continuously until conversion enable is cleared.
// - Result resolved bit 9 down to 0; end request raised at transfer.
module sarcc_top
	import sarcc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic [15:0] BUS_ADDR,
	input  wire logic [15:0] BUS_WDATA,
	input  wire logic        BUS_RD,
	input  wire logic        BUS_WR,
	input  wire logic        BUS_WIDE,
	output logic      [15:0] BUS_RDATA,
	output logic             BUS_WAIT,
	input  wire logic        COMP_OUT,
	output logic             COMP_ENABLE,
	output logic             ANA_SAMPLE,
	output logic      [9:0]  ANA_TAP,
	output logic      [2:0]  ANA_CHANNEL,
	output logic      [3:0]  ANA_PIN_CFG,
	output logic             CONV_END_IRQ
);
	sarcc_mode_t  mode_q;
	sarcc_state_t state_q;
	logic [2:0]   chan_q;
	logic [3:0]   pin_q;
	logic [15:0]  result_wide_q;
	logic [7:0]   result_upper_q;
	logic [15:0]  rdata_q;
	logic [15:0]  rdata_d;
	logic [9:0]   sar_q;
	logic [4:0]   cnt_q;
	logic [3:0]   bit_idx;
	logic         wait_q;
	logic         need_wait;
	logic         rd_take;
	logic         wr_take;
	logic         fad_tick;
	logic         load_now;
	logic         conv_end_q;
	logic         comp_hold_q;

	// Bus timing: these accesses stretch by one wait cycle
	assign need_wait = (BUS_RD && ((BUS_ADDR == ADDR_RESULT_WIDE) || (BUS_ADDR == ADDR_RESULT_UPPER)))
		|| (BUS_WR && ((BUS_ADDR == ADDR_MODE) || (BUS_ADDR == ADDR_CHANNEL) || (BUS_ADDR == ADDR_PIN_CFG)));
	assign BUS_WAIT  = need_wait && !wait_q;
	assign rd_take   = BUS_RD && !BUS_WAIT;
	assign wr_take   = BUS_WR && !BUS_WAIT;
	assign BUS_RDATA = rdata_q;

	// Wait state flag
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			wait_q <= 1'b0;
		else
			wait_q <= need_wait && !wait_q;
	end

	// Writable registers; result addresses are not decoded for writes, results kept on these writes
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			mode_q <= MODE_RESET;
			chan_q <= CHANNEL_RESET;
			pin_q  <= PIN_CFG_RESET;
		end
		else if (wr_take)
		begin
			case (BUS_ADDR)
				ADDR_MODE:    mode_q <= BUS_WDATA[7:0] & MODE_WR_MASK;
				ADDR_CHANNEL: chan_q <= BUS_WDATA[2:0];
				ADDR_PIN_CFG: pin_q  <= BUS_WDATA[3:0];
				default:      mode_q <= mode_q;
			endcase
		end
	end

	// Read multiplexer
	always_comb
	begin
		rdata_d = 16'h0000;
		case (BUS_ADDR)
			ADDR_RESULT_WIDE:  rdata_d = BUS_WIDE ? result_wide_q : 16'h0000;
			ADDR_RESULT_UPPER: rdata_d = BUS_WIDE ? 16'h0000 : {8'h00, result_upper_q};
			ADDR_MODE:         rdata_d = {8'h00, mode_q};
			ADDR_CHANNEL:      rdata_d = {13'h0000, chan_q};
			ADDR_PIN_CFG:      rdata_d = {12'h000, pin_q};
			default:           rdata_d = 16'h0000;
		endcase
	end

	// Read data register, updated when a read is taken
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			rdata_q <= 16'h0000;
		else if (rd_take)
			rdata_q <= rdata_d;
	end

	// Comparator decision capture; the comparator answers the tap this clock drives,
	// so one flop keeps each decision in time even with a two-clock conversion tick
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			comp_hold_q <= 1'b0;
		else
			comp_hold_q <= COMP_OUT;
	end

	// Conversion clock
	sarcc_fad_div u_fad_div (
		.clk         (CLK),
		.rst         (SYS_RST),
		.run         (mode_q.conv_enable),
		.divider_sel (mode_q.divider_sel),
		.tick        (fad_tick)
	);

	assign bit_idx  = SAR_TOP_BIT - cnt_q[3:0];
	assign load_now = mode_q.conv_enable && fad_tick && (state_q == ST_TRANSFER) && (cnt_q == 5'h00);

	// Conversion sequencer: clear, sample, compare, transfer, repeat
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 5'h00;
			sar_q   <= SAR_RESET;
		end
		else if (!mode_q.conv_enable)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 5'h00;
		end
		else if (state_q == ST_IDLE)
		begin
			state_q <= ST_CLEAR;
			cnt_q   <= 5'h00;
		end
		else if (fad_tick)
		begin
			case (state_q)
				ST_CLEAR:
				begin
					sar_q <= SAR_RESET;
					if (cnt_q == (TICKS_CLEAR - 5'h01))
					begin
						state_q <= ST_SAMPLE;
						cnt_q   <= 5'h00;
					end
					else
						cnt_q <= cnt_q + 5'h01;
				end
				ST_SAMPLE:
				begin
					if (cnt_q == (sarcc_sample_len(mode_q.level_sel) - 5'h01))
					begin
						state_q <= ST_COMPARE;
						cnt_q   <= 5'h00;
						sar_q   <= SAR_FIRST_TRIAL;
					end
					else
						cnt_q <= cnt_q + 5'h01;
				end
				ST_COMPARE:
				begin
					if (cnt_q < TICKS_RESOLVE)
					begin
						if (!comp_hold_q)
							sar_q[bit_idx] <= 1'b0;
						if (bit_idx != 4'h0)
							sar_q[bit_idx - 4'h1] <= 1'b1;
					end
					if (cnt_q == (TICKS_COMPARE - 5'h01))
					begin
						state_q <= ST_TRANSFER;
						cnt_q   <= 5'h00;
					end
					else
						cnt_q <= cnt_q + 5'h01;
				end
				ST_TRANSFER:
				begin
					if (cnt_q == (TICKS_TRANSFER - 5'h01))
					begin
						state_q <= ST_CLEAR;
						cnt_q   <= 5'h00;
					end
					else
						cnt_q <= cnt_q + 5'h01;
				end
				default:
				begin
					state_q <= ST_IDLE;
					cnt_q   <= 5'h00;
				end
			endcase
		end
	end

	// Result registers, loaded at the first transfer tick
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			result_wide_q  <= RESULT_WIDE_RESET;
			result_upper_q <= RESULT_UPPER_RESET;
		end
		else if (load_now)
		begin
			result_wide_q  <= {sar_q, RESULT_PAD};
			result_upper_q <= sar_q[9:2];
		end
	end

	// Conversion end request, raised on the same clock edge as the result load
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			conv_end_q <= 1'b0;
		else
			conv_end_q <= load_now;
	end

	// Front end drive
	assign CONV_END_IRQ = conv_end_q;
	assign COMP_ENABLE  = mode_q.comparator_enable;
	assign ANA_SAMPLE   = (state_q == ST_SAMPLE);
	assign ANA_TAP      = sar_q;
	assign ANA_CHANNEL  = chan_q;
	assign ANA_PIN_CFG  = pin_q;

	chk_low_bits_zero: assert property (@(posedge CLK) disable iff (SYS_RST) result_wide_q[5:0] == 6'h00)
		else $error("wide result low bits not zero");
	chk_byte_mirror: assert property (@(posedge CLK) disable iff (SYS_RST) result_upper_q == result_wide_q[15:8])
		else $error("byte result differs from wide result upper byte");
	chk_reset_clear: assert property (@(posedge CLK) SYS_RST |=> (result_wide_q == 16'h0000 && result_upper_q == 8'h00))
		else $error("result registers not cleared by reset");
	chk_load_result: assert property (@(posedge CLK) disable iff (SYS_RST)
		load_now |=> (result_wide_q[15:6] == $past(sar_q)) && CONV_END_IRQ)
		else $error("result not loaded or end request missing");
	chk_irq_pulse: assert property (@(posedge CLK) disable iff (SYS_RST) CONV_END_IRQ |=> !CONV_END_IRQ)
		else $error("end request longer than one clock");
	chk_read_wait: assert property (@(posedge CLK) disable iff (SYS_RST)
		(BUS_RD && BUS_ADDR == ADDR_RESULT_WIDE && !wait_q) |-> BUS_WAIT ##1 !BUS_WAIT)
		else $error("result read without exactly one wait");
	chk_chan_wait: assert property (@(posedge CLK) disable iff (SYS_RST)
		(BUS_WR && BUS_ADDR == ADDR_CHANNEL && !wait_q) |-> BUS_WAIT ##1 !BUS_WAIT)
		else $error("channel write without exactly one wait");
	chk_write_ignored: assert property (@(posedge CLK) disable iff (SYS_RST)
		(wr_take && BUS_ADDR == ADDR_RESULT_WIDE && !load_now) |=> $stable(result_wide_q))
		else $error("result register changed by a write");
	chk_stop_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
		!mode_q.conv_enable |=> (state_q == ST_IDLE) && !CONV_END_IRQ)
		else $error("sequencer running while conversion disabled");
endmodule // sarcc_top
`default_nettype wire

// >>> test_sar_adc_result_channel_ctrl.sv
// Self-checking bench for the SAR converter control block
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_result_channel_ctrl
	import sarcc_pkg::*;
;
	logic        CLK, SYS_RST, BUS_RD, BUS_WR, BUS_WIDE, BUS_WAIT, COMP_OUT, COMP_ENABLE, ANA_SAMPLE, CONV_END_IRQ;
	logic [15:0] BUS_ADDR, BUS_WDATA, BUS_RDATA;
	logic [9:0]  ANA_TAP, level;
	logic [2:0]  ANA_CHANNEL;
	logic [3:0]  ANA_PIN_CFG;
	int          n_fail, compares, cycles;

	sarcc_top i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_RD(BUS_RD),
		.BUS_WR(BUS_WR), .BUS_WIDE(BUS_WIDE), .BUS_RDATA(BUS_RDATA), .BUS_WAIT(BUS_WAIT), .COMP_OUT(COMP_OUT),
		.COMP_ENABLE(COMP_ENABLE), .ANA_SAMPLE(ANA_SAMPLE), .ANA_TAP(ANA_TAP), .ANA_CHANNEL(ANA_CHANNEL),
		.ANA_PIN_CFG(ANA_PIN_CFG), .CONV_END_IRQ(CONV_END_IRQ));

	sarcc_afe_model i_afe (.clk(CLK), .comp_enable(COMP_ENABLE), .sample(ANA_SAMPLE), .tap(ANA_TAP),
		.level(level), .comp_out(COMP_OUT));

	// Clock
	initial
	begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	task automatic print_verdict();
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge CLK)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			n_fail = n_fail + 1;
			print_verdict();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares = compares + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus transfer, held through the wait cycle
	task automatic bus(input logic wr, input logic wide, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic w);
		@(negedge CLK);
		BUS_ADDR = a;
		BUS_WDATA = d;
		BUS_RD = ~wr;
		BUS_WR = wr;
		BUS_WIDE = wide;
		#1 w = BUS_WAIT;
		@(posedge CLK);
		if (w)
			@(posedge CLK);
		@(negedge CLK);
		q = BUS_RDATA;
		BUS_RD = 1'b0;
		BUS_WR = 1'b0;
	endtask

	// Cycles until the next end-of-conversion pulse
	task automatic wait_irq(output int n);
		n = 0;
		do
		begin
			@(posedge CLK);
			#1 n = n + 1;
		end
		while (CONV_END_IRQ !== 1'b1 && n < 1000);
	endtask

	task automatic t_reset();
		logic [15:0] q;
		logic        w;
		bus(1'b0, 1'b1, ADDR_RESULT_WIDE, 16'h0000, q, w);
		check(q, 16'h0000);
		check({15'h0000, w}, 16'h0001);
		bus(1'b0, 1'b0, ADDR_RESULT_UPPER, 16'h0000, q, w);
		check(q, 16'h0000);
		check({15'h0000, w}, 16'h0001);
		bus(1'b0, 1'b0, ADDR_CHANNEL, 16'h0000, q, w);
		check(q, 16'h0000);
	endtask

	task automatic t_regs();
		logic [15:0] q;
		logic        w;
		for (int c = 0; c < 8; c++)
		begin
			bus(1'b1, 1'b0, ADDR_CHANNEL, {13'h0000, 3'(c)}, q, w);
			check({15'h0000, w}, 16'h0001);
			check({13'h0000, ANA_CHANNEL}, 16'(c));
			bus(1'b0, 1'b0, ADDR_CHANNEL, 16'h0000, q, w);
			check(q, 16'(c));
		end
		bus(1'b1, 1'b0, ADDR_MODE, 16'h007F, q, w);
		bus(1'b0, 1'b0, ADDR_MODE, 16'h0000, q, w);
		check(q, 16'h003F);
		check({15'h0000, COMP_ENABLE}, 16'h0001);
		bus(1'b1, 1'b0, ADDR_PIN_CFG, 16'h000A, q, w);
		check({12'h000, ANA_PIN_CFG}, 16'h000A);
		bus(1'b1, 1'b0, ADDR_PIN_CFG, 16'h0000, q, w);
		bus(1'b0, 1'b0, 16'hFF00, 16'h0000, q, w);
		check(q, 16'h0000);
	endtask

	// One divider code: period, result layout and access widths
	task automatic t_conv(input logic [2:0] div, input logic [9:0] code, input logic [8:0] total,
		input logic [1:0] lv);
		sarcc_mode_t m;
		logic [15:0] q;
		logic        w;
		int          n;
		m = '{conv_enable: 1'b0, zero_bit: 1'b0, divider_sel: div, level_sel: lv, comparator_enable: 1'b1};
		bus(1'b1, 1'b0, ADDR_MODE, {8'h00, m}, q, w);
		bus(1'b1, 1'b0, ADDR_CHANNEL, {13'h0000, div}, q, w);
		level = code;
		repeat (50) @(posedge CLK);
		m.conv_enable = 1'b1;
		bus(1'b1, 1'b0, ADDR_MODE, {8'h00, m}, q, w);
		wait_irq(n);
		wait_irq(n);
		check(16'(n), 16'(total));
		check({6'h00, ANA_TAP}, {6'h00, code});
		check({15'h0000, ANA_SAMPLE}, 16'h0000);
		bus(1'b0, 1'b1, ADDR_RESULT_WIDE, 16'h0000, q, w);
		check(q, {code, 6'h00});
		bus(1'b0, 1'b0, ADDR_RESULT_UPPER, 16'h0000, q, w);
		check(q, {8'h00, code[9:2]});
		bus(1'b0, 1'b0, ADDR_RESULT_WIDE, 16'h0000, q, w);
		check(q, 16'h0000);
		bus(1'b0, 1'b1, ADDR_RESULT_UPPER, 16'h0000, q, w);
		check(q, 16'h0000);
		bus(1'b1, 1'b1, ADDR_RESULT_WIDE, 16'h5555, q, w);
		bus(1'b1, 1'b0, ADDR_RESULT_UPPER, 16'h00AA, q, w);
		bus(1'b0, 1'b1, ADDR_RESULT_WIDE, 16'h0000, q, w);
		check(q, {code, 6'h00});
		bus(1'b0, 1'b0, ADDR_RESULT_UPPER, 16'h0000, q, w);
		check(q, {8'h00, code[9:2]});
		m.conv_enable = 1'b0;
		bus(1'b1, 1'b0, ADDR_MODE, {8'h00, m}, q, w);
		wait_irq(n);
		check(16'(n), 16'd1000);
	endtask

	// Main sequence
	initial
	begin
		{BUS_RD, BUS_WR, BUS_WIDE} = 3'h0;
		BUS_ADDR = 16'h0000;
		BUS_WDATA = 16'h0000;
		level = 10'h000;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		SYS_RST = 1'b1;
		repeat (16) @(posedge CLK);
		@(negedge CLK);
		SYS_RST = 1'b0;
		t_reset();
		t_regs();
		t_conv(3'h0, 10'h3FF, 9'd480, 2'h1);
		t_conv(3'h1, 10'h000, 9'd320, 2'h1);
		t_conv(3'h2, 10'h2A5, 9'd240, 2'h1);
		t_conv(3'h3, 10'h15A, 9'd160, 2'h1);
		t_conv(3'h4, 10'h200, 9'd120, 2'h1);
		t_conv(3'h5, 10'h1FF, 9'd80, 2'h1);
		t_conv(3'h0, 10'h155, 9'd264, 2'h0);
		print_verdict();
	end
endmodule // test_sar_adc_result_channel_ctrl
`default_nettype wire
